/* design/scc_standby_ctrl.v */
/*
 * standby and clock-mode control: stop/wait states, stop lock,
 * watchdog, oscillator enables, shared timer mode register, lcd mode.
 * assumes the cpu raises one-cycle strobes for the stop and wait
 * instructions, and that irq_req is synchronous to clk.
 */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "scc_consts.vh"

// Overview of operation
// - once the stop-disable bit is set, stop stays refused until reset.
// - the watchdog keeps counting in wait mode and may underflow there.
// - the watchdog halts in stop mode and runs again during stabilisation.
// - the watchdog ticks at the rate of the selected system clock.
// - stop release by interrupt clears the timer mode register but bit 4.
// - an interrupt in stop mode ends stop and restarts the oscillators that ran before stop.
// - main stabilisation delay is inserted when main both ran and drove the system clock.
// - the lcd clock source bit reads zero after reset.
// - the sub oscillator is stopped after reset.
// - reset in wait on sub clock stops sub and starts main oscillator.
module scc_standby_ctrl #(
    parameter MAIN_STAB_CYC = `SCC_MAIN_STAB_CYC
) (
    clk,
    resetn,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    stop_instruction,
    wait_instruction,
    irq_req,
    cpu_clk_en,
    periph_clk_en,
    main_osc_en,
    sub_osc_en,
    sys_tick,
    lcd_timing_clock,
    wdt_underflow,
    stop_refused
);
    input  wire        clk;
    input  wire        resetn;
    input  wire [7:0]  addr;
    input  wire [7:0]  wdata;
    input  wire        wr;
    input  wire        rd;
    output reg  [7:0]  rdata;
    input  wire        stop_instruction;
    input  wire        wait_instruction;
    input  wire        irq_req;
    output wire        cpu_clk_en;
    output wire        periph_clk_en;
    output reg         main_osc_en;
    output reg         sub_osc_en;
    output wire        sys_tick;
    output wire        lcd_timing_clock;
    output reg         wdt_underflow;
    output reg         stop_refused;

    reg  [1:0]         state_ff;
    reg  [1:0]         nxt_state;
    reg                stop_lock_ff;
    reg  [7:0]         cpu_mode_ff;
    reg  [7:0]         lcd_mode_ff;
    reg  [7:0]         tmr_mode_ff;
    reg  [15:0]        wdt_cnt_ff;
    reg  [15:0]        stab_cnt_ff;
    reg                sub_halted_ff;
    reg                main_halted_ff;
    wire               sub_tick;
    wire               sub_lcd_tick;
    wire               main_sys;
    wire               wdt_run;
    wire               wdt_load;
    wire               stop_ok;
    wire               need_stab;

    localparam integer STAB_LAST_I = MAIN_STAB_CYC - 1;
    localparam [15:0]  STAB_LAST   = STAB_LAST_I[15:0];

    assign main_sys = !cpu_mode_ff[`SCC_CPU_SYSCLK_BIT];
    // system clock rate
    // no tick in stop, whichever oscillator is selected
    assign sys_tick = (state_ff != `SCC_ST_STOP) && (main_sys || sub_tick);

    scc_divider #(.DIV(`SCC_SUB_DIV)) u_sub_div (
        .clk    (clk),
        .resetn (resetn),
        .run    (sub_osc_en && state_ff != `SCC_ST_STOP),
        .tick   (sub_tick)
    );

    scc_divider #(.DIV(`SCC_LCD_DIV)) u_lcd_div (
        .clk    (clk),
        .resetn (resetn),
        .run    (lcd_mode_ff[`SCC_LCD_EN_BIT] &&
                 (lcd_mode_ff[`SCC_LCD_SRC_BIT] ? main_osc_en
                                                 : sub_osc_en) &&
                 state_ff != `SCC_ST_STOP),
        .tick   (sub_lcd_tick)
    );
    assign lcd_timing_clock = sub_lcd_tick;

    assign cpu_clk_en    = (state_ff == `SCC_ST_RUN);
    assign periph_clk_en = (state_ff == `SCC_ST_RUN) ||
                           (state_ff == `SCC_ST_WAIT);

    assign stop_ok   = !stop_lock_ff;
    assign need_stab = main_sys && !main_halted_ff;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `SCC_ST_RUN: begin
                if (stop_instruction && stop_ok) begin
                    nxt_state = `SCC_ST_STOP;
                end else if (wait_instruction) begin
                    nxt_state = `SCC_ST_WAIT;
                end
            end
            `SCC_ST_WAIT: begin
                if (irq_req) begin
                    nxt_state = `SCC_ST_RUN;
                end
            end
            `SCC_ST_STOP: begin
                if (irq_req) begin
                    nxt_state = need_stab ? `SCC_ST_STAB : `SCC_ST_RUN;
                end
            end
            `SCC_ST_STAB: begin
                if (stab_cnt_ff == STAB_LAST) begin
                    nxt_state = `SCC_ST_RUN;
                end
            end
            default: nxt_state = `SCC_ST_RUN;
        endcase
    end

    assign wdt_load = wr && (addr == `SCC_ADDR_WDT_CTRL) &&
                      state_ff == `SCC_ST_RUN;
    // watchdog runs in wait and stabilisation, not in stop
    assign wdt_run  = sys_tick && state_ff != `SCC_ST_STOP;

    always @(posedge clk) begin
        if (!resetn) begin
            state_ff       <= `SCC_ST_RUN;
            stop_lock_ff   <= 1'b0;
            lcd_mode_ff    <= `SCC_LCD_MODE_RST;
            cpu_mode_ff    <= `SCC_CPU_MODE_RST;
            tmr_mode_ff    <= `SCC_TMR_MODE_RST;
            wdt_cnt_ff     <= `SCC_WDT_LOAD;
            stab_cnt_ff    <= 16'h0000;
            main_osc_en    <= 1'b1;
            sub_osc_en     <= 1'b0;
            sub_halted_ff  <= 1'b0;
            main_halted_ff <= 1'b0;
            wdt_underflow  <= 1'b0;
            stop_refused   <= 1'b0;
            rdata          <= 8'h00;
        end else begin
            state_ff      <= nxt_state;
            stop_refused  <= stop_instruction && !stop_ok;
            wdt_underflow <= 1'b0;
            stab_cnt_ff   <= (state_ff == `SCC_ST_STAB) ?
                             stab_cnt_ff + 16'h0001 : 16'h0000;
            if (wr && addr == `SCC_ADDR_WDT_CTRL) begin
                if (wdata[`SCC_WDT_STOP_DIS_BIT]) begin
                    stop_lock_ff <= 1'b1;
                end
            end
            if (wr && addr == `SCC_ADDR_CPU_MODE) begin
                cpu_mode_ff <= wdata;
                main_osc_en <= !wdata[`SCC_CPU_MAIN_STOP];
                sub_osc_en  <= wdata[`SCC_CPU_SUB_RUN];
            end
            if (wr && addr == `SCC_ADDR_LCD_MODE) begin
                lcd_mode_ff <= wdata;
            end
            if (wr && addr == `SCC_ADDR_TMR_MODE) begin
                tmr_mode_ff <= wdata;
            end
            if (wdt_load) begin
                wdt_cnt_ff <= `SCC_WDT_LOAD;
            end else if (wdt_run) begin
                if (wdt_cnt_ff == 16'h0000) begin
                    wdt_underflow <= 1'b1;
                    wdt_cnt_ff    <= `SCC_WDT_LOAD;
                end else begin
                    wdt_cnt_ff <= wdt_cnt_ff - 16'h0001;
                end
            end
            if (state_ff == `SCC_ST_RUN && nxt_state == `SCC_ST_STOP) begin
                main_halted_ff <= !main_osc_en;
                sub_halted_ff  <= !sub_osc_en;
                main_osc_en    <= 1'b0;
                sub_osc_en     <= 1'b0;
            end
            if (state_ff == `SCC_ST_STOP && irq_req) begin
                tmr_mode_ff <= tmr_mode_ff & (8'h01 << `SCC_TMR_KEEP_BIT);
                main_osc_en <= !main_halted_ff;
                sub_osc_en  <= !sub_halted_ff;
            end
            if (rd) begin
                case (addr)
                    `SCC_ADDR_WDT_CTRL:
                        rdata <= {1'b0, stop_lock_ff, wdt_cnt_ff[15:10]};
                    `SCC_ADDR_CPU_MODE: rdata <= cpu_mode_ff;
                    `SCC_ADDR_LCD_MODE: rdata <= lcd_mode_ff;
                    `SCC_ADDR_TMR_MODE: rdata <= tmr_mode_ff;
                    `SCC_ADDR_STATUS:
                        rdata <= {4'h0, main_osc_en, sub_osc_en, state_ff};
                    default:            rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule // scc_standby_ctrl

/* design/scc_consts.vh */
/*
 * constants for the standby and clock control block: register
 * offsets, field positions, reset values and timing counts.
 * assumes inclusion by bare name from design files only.
 */
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// register offsets on the plain register port
`define SCC_ADDR_WDT_CTRL    8'h37
`define SCC_ADDR_LCD_MODE    8'h39
`define SCC_ADDR_CPU_MODE    8'h3b
`define SCC_ADDR_TMR_MODE    8'h29
`define SCC_ADDR_STATUS      8'h2a

// field positions
`define SCC_WDT_STOP_DIS_BIT 6
`define SCC_CPU_SYSCLK_BIT   7
`define SCC_CPU_MAIN_STOP    5
`define SCC_CPU_SUB_RUN      4
`define SCC_LCD_SRC_BIT      7
`define SCC_LCD_EN_BIT       3
`define SCC_TMR_KEEP_BIT     4

// reset values
`define SCC_CPU_MODE_RST     8'h00
`define SCC_LCD_MODE_RST     8'h00
`define SCC_TMR_MODE_RST     8'h00

// watchdog preload on a control write
`define SCC_WDT_LOAD         16'hffff

// stabilisation times in microseconds, and cycles at 10 MHz
`define SCC_CLK_MHZ          10
`define SCC_MAIN_STAB_US     1000
`define SCC_MAIN_STAB_CYC    (`SCC_MAIN_STAB_US * `SCC_CLK_MHZ)
`define SCC_SUB_DIV          4
`define SCC_LCD_DIV          32

// standby states
`define SCC_ST_RUN           2'h0
`define SCC_ST_WAIT          2'h1
`define SCC_ST_STOP          2'h2
`define SCC_ST_STAB          2'h3

`endif

/* design/scc_divider.v */
/*
 * enable-pulse divider: one-cycle pulse every DIV clocks while run is
 * high. assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/10ps

module scc_divider #(
    parameter DIV = 4
) (
    clk,
    resetn,
    run,
    tick
);
    input  wire       clk;
    input  wire       resetn;
    input  wire       run;
    output wire       tick;

    reg  [7:0]        cnt_ff;
    wire [7:0]        nxt_cnt;

    localparam integer LAST_I = DIV - 1;
    localparam [7:0]   LAST   = LAST_I[7:0];

    assign nxt_cnt = (!run || cnt_ff == LAST) ? 8'h00 : cnt_ff + 8'h01;
    assign tick    = run && (cnt_ff == LAST);

    always @(posedge clk) begin
        if (!resetn) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // scc_divider

/* test/scc_standby_monitor.sv */
/* port assertions for the standby and clock control block.
   assumes a bind to scc_standby_ctrl, one clock, sync reset. */
`timescale 1ns/10ps
module scc_standby_monitor #(
    parameter MAIN_STAB_CYC = 8
) (
    input wire       clk,
    input wire       resetn,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       stop_instruction,
    input wire       wait_instruction,
    input wire       irq_req,
    input wire       cpu_clk_en,
    input wire       periph_clk_en,
    input wire       main_osc_en,
    input wire       sub_osc_en,
    input wire       sys_tick,
    input wire       lcd_timing_clock,
    input wire       wdt_underflow,
    input wire       stop_refused
);
    reg  lock_ff, sub_sel_ff, in_stop_ff, main_ff;
    wire acc_stop = stop_instruction & cpu_clk_en & ~lock_ff;

    // shadows of lock, clock select and stop state
    always @(posedge clk) begin
        if (!resetn) begin
            lock_ff    <= 1'h0;
            sub_sel_ff <= 1'h0;
            in_stop_ff <= 1'h0;
            main_ff    <= 1'h0;
        end else begin
            if (wr && addr == 8'h37 && wdata[6])
                lock_ff <= 1'h1;
            if (wr && addr == 8'h3b)
                sub_sel_ff <= wdata[7];
            if (acc_stop)
                main_ff <= main_osc_en & ~sub_sel_ff;
            if (acc_stop)
                in_stop_ff <= 1'h1;
            else if (irq_req)
                in_stop_ff <= 1'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_locked_stop: assert property (
        stop_instruction && cpu_clk_en && lock_ff |=> stop_refused && cpu_clk_en)
        else $error("stop taken while locked");
    a_stop_entry: assert property (
        acc_stop |=> !periph_clk_en && !main_osc_en && !sub_osc_en)
        else $error("stop did not halt clocks");
    a_stop_no_tick: assert property (
        in_stop_ff |-> !sys_tick && !lcd_timing_clock && !periph_clk_en)
        else $error("tick seen in stop");
    // repetition fixed at 8: the bench runs MAIN_STAB_CYC at 8
    a_stab_delay: assert property (
        in_stop_ff && irq_req && main_ff |=> !cpu_clk_en [*8] ##1 cpu_clk_en)
        else $error("main stabilisation length wrong");
    a_fast_wake: assert property (
        in_stop_ff && irq_req && !main_ff |=> cpu_clk_en)
        else $error("no prompt wake from stop");
    a_wait_entry: assert property (
        wait_instruction && !stop_instruction && cpu_clk_en
        |=> !cpu_clk_en && periph_clk_en)
        else $error("wait halted peripherals");
    a_wait_wake: assert property (
        !cpu_clk_en && periph_clk_en && irq_req |=> cpu_clk_en)
        else $error("no wake from wait");
    a_main_tick: assert property (
        !in_stop_ff && !sub_sel_ff |-> sys_tick)
        else $error("watchdog tick missing on main");
    a_reset_osc: assert property (
        $rose(resetn) |-> main_osc_en && !sub_osc_en)
        else $error("oscillators wrong after reset");
endmodule // scc_standby_monitor

bind scc_standby_ctrl scc_standby_monitor #(
    .MAIN_STAB_CYC(MAIN_STAB_CYC)
) u_monitor (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .stop_instruction, .wait_instruction, .irq_req, .cpu_clk_en,
    .periph_clk_en, .main_osc_en, .sub_osc_en, .sys_tick,
    .lcd_timing_clock, .wdt_underflow, .stop_refused);

/* test/tb.sv */
/* self-checking bench for the standby and clock control block.
   assumes scc_standby_ctrl and its checker are compiled first. */
`timescale 1ns/10ps
module tb;
    reg        clk, resetn, wr, rd, irq_req;
    reg        stop_instruction, wait_instruction;
    reg  [7:0] addr, wdata;
    wire [7:0] rdata;
    wire       cpu_clk_en, periph_clk_en, main_osc_en, sub_osc_en;
    wire       sys_tick, lcd_timing_clock, wdt_underflow, stop_refused;
    integer    n_errors = 0;
    integer    total_checks = 0;

    scc_standby_ctrl #(.MAIN_STAB_CYC(8)) i_scc_standby_ctrl (.clk,
        .resetn, .addr, .wdata, .wr, .rd, .rdata, .stop_instruction,
        .wait_instruction, .irq_req, .cpu_clk_en, .periph_clk_en,
        .main_osc_en, .sub_osc_en, .sys_tick, .lcd_timing_clock,
        .wdt_underflow, .stop_refused);

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task wrap_up;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input [7:0] s, input [7:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: got %h want %h", $time, s, e);
            end
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= d;
            wr    <= 1'h1;
            @(posedge clk);
            wr    <= 1'h0;
            #1;
        end
    endtask

    task rd_reg(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'h1;
            @(posedge clk);
            rd   <= 1'h0;
            #1 chk(rdata, e);
        end
    endtask

    // k is {irq, wait, stop}, one cycle high
    task cmd(input [2:0] k);
        begin
            @(posedge clk);
            {irq_req, wait_instruction, stop_instruction} <= k;
            @(posedge clk);
            {irq_req, wait_instruction, stop_instruction} <= 3'h0;
            #1;
        end
    endtask

    task count(input integer n, input lcd, input [7:0] e);
        integer c;
        begin
            c = 0;
            repeat (n) begin
                @(posedge clk);
                #1 if ((lcd ? lcd_timing_clock : sys_tick) === 1'h1)
                    c = c + 1;
            end
            chk(c[7:0], e);
        end
    endtask

    task pulse_reset;
        begin
            @(posedge clk);
            resetn <= 1'h0;
            tick(2);
            chk(main_osc_en, 8'h1);
            chk(sub_osc_en, 8'h0);
            @(posedge clk);
            resetn <= 1'h1;
        end
    endtask

    // a full run is near 71000 cycles, most of it the watchdog
    // underflow in wait; 9 ms leaves margin
    initial begin
        #9000000;
        n_errors = n_errors + 1;
        wrap_up;
    end

    initial begin
        {resetn, wr, rd, irq_req} = 4'h0;
        {stop_instruction, wait_instruction} = 2'h0;
        addr  = 8'h00;
        wdata = 8'h00;
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        tick(1);
        chk(sub_osc_en, 8'h0);
        rd_reg(8'h2a, 8'h08);
        rd_reg(8'h39, 8'h00);
        count(40, 1'h0, 8'd40);
        wr_reg(8'h39, 8'h08);
        count(64, 1'h1, 8'h0);
        wr_reg(8'h39, 8'h88);
        count(64, 1'h1, 8'h2);
        wr_reg(8'h39, 8'h00);
        wr_reg(8'h3b, 8'h10);
        tick(20);
        wr_reg(8'h3b, 8'h90);
        count(40, 1'h0, 8'd10);
        wr_reg(8'h37, 8'h00);
        cmd(3'h1);
        chk(periph_clk_en, 8'h0);
        chk(sub_osc_en, 8'h0);
        tick(20);
        chk(sys_tick, 8'h0);
        cmd(3'h4);
        chk(cpu_clk_en, 8'h1);
        chk(sub_osc_en, 8'h1);
        wr_reg(8'h3b, 8'hb0);
        chk(main_osc_en, 8'h0);
        cmd(3'h2);
        pulse_reset;
        wr_reg(8'h29, 8'hff);
        wr_reg(8'h37, 8'h00);
        cmd(3'h1);
        chk(main_osc_en, 8'h0);
        tick(3000);
        cmd(3'h4);
        chk(main_osc_en, 8'h1);
        chk(cpu_clk_en, 8'h0);
        tick(8);
        chk(cpu_clk_en, 8'h1);
        rd_reg(8'h29, 8'h10);
        rd_reg(8'h37, 8'h3f);
        wr_reg(8'h37, 8'h00);
        cmd(3'h2);
        chk(periph_clk_en, 8'h1);
        tick(2100);
        cmd(3'h4);
        rd_reg(8'h37, 8'h3d);
        wr_reg(8'h37, 8'h00);
        cmd(3'h2);
        tick(65533);
        chk(wdt_underflow, 8'h0);
        tick(1);
        chk(wdt_underflow, 8'h1);
        cmd(3'h4);
        wr_reg(8'h37, 8'h40);
        wr_reg(8'h37, 8'h00);
        rd_reg(8'h37, 8'h7f);
        cmd(3'h1);
        chk(stop_refused, 8'h1);
        chk(cpu_clk_en, 8'h1);
        pulse_reset;
        rd_reg(8'h37, 8'h3f);
        wrap_up;
    end
endmodule // tb
